// [shared/epcp_pkg.sv]
/*
  Shared constants and types of the encoder position and cam processing block:
  attribute numbers, reset values, field positions and the configuration carrier.
  Assumes a single 20 MHz clock domain and a network controller that reads and
  writes attributes by number.
*/
package epcp_pkg;

  // Attribute numbers as the controller addresses them.
  localparam logic [7:0] ATTR_PRESET    = 8'h67;
  localparam logic [7:0] ATTR_OFFSET    = 8'h68;
  localparam logic [7:0] ATTR_HYST      = 8'h69;
  localparam logic [7:0] ATTR_AVG       = 8'h6a;
  localparam logic [7:0] ATTR_GEAR_NUM  = 8'h6b;
  localparam logic [7:0] ATTR_GEAR_DEN  = 8'h6c;
  localparam logic [7:0] ATTR_END_LO    = 8'h6d;
  localparam logic [7:0] ATTR_END_HI    = 8'h6e;
  localparam logic [7:0] ATTR_FREQ_LIM  = 8'h6f;
  localparam logic [7:0] ATTR_FAULT     = 8'h70;
  localparam logic [7:0] ATTR_CAM_STATE = 8'h71;
  localparam logic [7:0] ATTR_CAM_EN    = 8'h72;
  localparam logic [7:0] ATTR_CAM_POL   = 8'h73;

  // Widths of the data path.
  localparam int POS_W      = 64;
  localparam int RAW_W      = 32;
  localparam int STEP_W     = 16;
  localparam int GEAR_OUT_W = 20;
  localparam int PROD_W     = 48;
  localparam int DIV_W      = 16;
  localparam int CAM_N      = 8;
  localparam int WARN_W     = 16;

  // Values after reset.
  localparam logic [7:0]  HYST_RST     = 8'h04;
  localparam logic [7:0]  AVG_RST      = 8'h01;
  localparam logic [15:0] GEAR_NUM_RST = 16'h0000;
  localparam logic [15:0] GEAR_DEN_RST = 16'h0000;
  localparam logic [15:0] FREQ_LIM_RST = 16'hffff;
  localparam logic [7:0]  CAM_EN_RST   = 8'h00;
  localparam logic [7:0]  CAM_POL_RST  = 8'h00;
  localparam logic [63:0] PRESET_RST   = 64'h0000_0000_0000_0000;
  localparam logic [63:0] END_LO_RST   = 64'h8000_0000_0000_0000;
  localparam logic [63:0] END_HI_RST   = 64'h7fff_ffff_ffff_ffff;

  // Bit positions in the warning word.
  localparam int WARN_FREQ_BIT  = 0;
  localparam int WARN_LIMIT_BIT = 10;

  // Cycle count of one division, one quotient bit per cycle.
  localparam logic [5:0] DIV_STEPS = 6'h30;

  typedef logic [CAM_N-1:0][POS_W-1:0] epcp_lim_t;

  typedef enum logic [1:0] {
    EPCP_IDLE,
    EPCP_GEAR,
    EPCP_AVG
  } epcp_proc_t;

  typedef struct packed {
    logic [63:0] preset;
    logic [63:0] end_lo;
    logic [63:0] end_hi;
    logic [15:0] gear_num;
    logic [15:0] gear_den;
    logic [15:0] freq_lim;
    logic [7:0]  hyst;
    logic [7:0]  avg_cnt;
    logic [7:0]  cam_en;
    logic [7:0]  cam_pol;
  } epcp_cfg_t;

endpackage : epcp_pkg

// [rtl/epcp_div.sv]
/*
  Sequential unsigned divider, one quotient bit per clock, shared by gear
  scaling and position averaging.
  Assumes the caller holds off a new start while busy and never divides by zero.
*/
`timescale 1ns/100ps
module epcp_div (
  input  wire logic                       i_clk,
  input  wire logic                       i_rstn,
  input  wire logic                       i_start,
  input  wire logic [epcp_pkg::PROD_W-1:0] i_dividend,
  input  wire logic [epcp_pkg::DIV_W-1:0]  i_divisor,
  output logic                            o_busy,
  output logic                            o_done,
  output logic [epcp_pkg::PROD_W-1:0]     o_quot
);

  localparam int DIV_W = epcp_pkg::DIV_W;

  logic [epcp_pkg::DIV_W-1:0]  rem_q;
  logic [epcp_pkg::DIV_W-1:0]  dvs_q;
  logic [5:0]                  cnt_q;
  logic [epcp_pkg::DIV_W:0]    trial;
  logic                        fits;

  assign trial = {rem_q, o_quot[epcp_pkg::PROD_W-1]};
  assign fits  = trial >= {1'b0, dvs_q};

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rem_q  <= '0;
      dvs_q  <= '0;
      cnt_q  <= '0;
      o_quot <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start && !o_busy)
      begin
        rem_q  <= '0;
        dvs_q  <= i_divisor;
        o_quot <= i_dividend;
        cnt_q  <= epcp_pkg::DIV_STEPS;
        o_busy <= 1'b1;
      end
      else if (o_busy)
      begin
        rem_q  <= fits ? DIV_W'(trial - {1'b0, dvs_q}) : trial[epcp_pkg::DIV_W-1:0];
        o_quot <= {o_quot[epcp_pkg::PROD_W-2:0], fits};
        cnt_q  <= cnt_q - 6'h01;
        if (cnt_q == 6'h01)
        begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

endmodule : epcp_div

// [rtl/epcp_top.sv]
/*
  Encoder position post-processing and eight-channel cam unit: gear scaling,
  averaging, hysteresis, preset and offset, end-position and frequency warnings,
  and cam state, enable and polarity, reached as attributes by number.
  Assumes raw position, rotation frequency, fault word and cam limits come from
  logic on the same 20 MHz clock, and attribute requests arrive as one-cycle
  write strobes with the attribute number held alongside.
*/
// Behaviour
// [R1] The reported position moves only when the new value differs from it by more than an 8-bit band that resets to four.
// [R2] The position is averaged over a settable 8-bit number of samples.
// [R3] The position is multiplied by a 16-bit gear numerator and divided by a 16-bit gear denominator.
// [R4] With gear scaling active the result is held to 20 bits, at most 1,048,576 steps.
// [R5] Gear scaling always works from the 16-bit raw resolution per revolution.
// [R6] A settable rotation frequency threshold decides the frequency bit of the warning word.
// [R7] A read-only cam state byte shows each cam's switching state for the current position.
// [R8] A cam works only when the controller has written a one to its enable bit.
// [R9] With default polarity a cam reads one while the position lies within its limits.
// [R10] Each cam's sense is inverted by its own bit in a writable polarity byte.
// [R11] Applying a preset stores preset minus current position as a read-only offset.
// [R12] A position below the lower end limit is flagged.
// [R13] A position above the upper end limit is flagged.
// [R14] Warning bits clear by themselves once the watched values are back in range.
// [R15] Bit n of the cam state, enable and polarity bytes belongs to cam n plus one.
// [R16] A disabled cam always reads zero in the cam state byte.
`timescale 1ns/100ps
module epcp_top (
  input  wire logic                        i_clk,
  input  wire logic                        i_rstn,
  input  wire logic                        i_raw_valid,
  input  wire logic [epcp_pkg::RAW_W-1:0]  i_raw_pos,
  input  wire logic [15:0]                 i_rot_freq,
  input  wire logic [15:0]                 i_sensor_fault,
  input  wire epcp_pkg::epcp_lim_t         i_cam_lo,
  input  wire epcp_pkg::epcp_lim_t         i_cam_hi,
  input  wire logic [7:0]                  i_attr_id,
  input  wire logic                        i_attr_wr,
  input  wire logic [63:0]                 i_attr_wdata,
  output logic [63:0]                      o_attr_rdata,
  output logic                             o_attr_hit,
  output logic [epcp_pkg::POS_W-1:0]       o_position,
  output logic                             o_pos_valid,
  output logic [epcp_pkg::CAM_N-1:0]       o_cam_state,
  output logic [epcp_pkg::WARN_W-1:0]      o_warnings,
  output logic                             o_below_low,
  output logic                             o_above_high,
  output logic                             o_busy
);

  localparam int POS_W      = epcp_pkg::POS_W;
  localparam int PROD_W     = epcp_pkg::PROD_W;
  localparam int RAW_W      = epcp_pkg::RAW_W;
  localparam int GEAR_OUT_W = epcp_pkg::GEAR_OUT_W;

  epcp_pkg::epcp_cfg_t                   cfg_q;
  epcp_pkg::epcp_proc_t                  st_q;
  logic [63:0]                           offset_q;
  logic [epcp_pkg::PROD_W-1:0]           acc_q;
  logic [7:0]                            cnt_q;
  logic [epcp_pkg::POS_W-1:0]            avg_pos_q;
  logic                                  avg_vld_q;
  logic [epcp_pkg::POS_W-1:0]            hyst_pos_q;
  logic                                  have_q;
  logic                                  hyst_upd_q;
  logic [epcp_pkg::POS_W-1:0]            pos_q;
  logic                                  pos_vld_q;
  logic                                  gear_on;
  logic                                  wr_preset;
  logic                                  div_start;
  logic [epcp_pkg::PROD_W-1:0]           div_dividend;
  logic [epcp_pkg::DIV_W-1:0]            div_divisor;
  logic                                  div_busy;
  logic                                  div_done;
  logic [epcp_pkg::PROD_W-1:0]           div_quot;
  logic [epcp_pkg::RAW_W-1:0]            gear_src;
  logic [epcp_pkg::PROD_W-1:0]           sample;
  logic                                  sample_vld;
  logic [epcp_pkg::PROD_W-1:0]           acc_next;
  logic signed [epcp_pkg::POS_W-1:0]     hyst_diff;
  logic [epcp_pkg::POS_W-1:0]            hyst_mag;
  logic [epcp_pkg::CAM_N-1:0]            cam_d;

  // Gear scaling runs only with both numerator and denominator non-zero.
  assign gear_on   = (cfg_q.gear_num != 16'h0000) && (cfg_q.gear_den != 16'h0000);
  assign wr_preset = i_attr_wr && (i_attr_id == epcp_pkg::ATTR_PRESET);

  // Configuration attributes written by the controller.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cfg_q.preset   <= epcp_pkg::PRESET_RST;
      cfg_q.end_lo   <= epcp_pkg::END_LO_RST;
      cfg_q.end_hi   <= epcp_pkg::END_HI_RST;
      cfg_q.gear_num <= epcp_pkg::GEAR_NUM_RST;
      cfg_q.gear_den <= epcp_pkg::GEAR_DEN_RST;
      cfg_q.freq_lim <= epcp_pkg::FREQ_LIM_RST;
      cfg_q.hyst     <= epcp_pkg::HYST_RST;
      cfg_q.avg_cnt  <= epcp_pkg::AVG_RST;
      cfg_q.cam_en   <= epcp_pkg::CAM_EN_RST;
      cfg_q.cam_pol  <= epcp_pkg::CAM_POL_RST;
    end
    else if (i_attr_wr)
    begin
      unique case (i_attr_id)
        epcp_pkg::ATTR_PRESET:   cfg_q.preset   <= i_attr_wdata;
        epcp_pkg::ATTR_END_LO:   cfg_q.end_lo   <= i_attr_wdata;
        epcp_pkg::ATTR_END_HI:   cfg_q.end_hi   <= i_attr_wdata;
        epcp_pkg::ATTR_GEAR_NUM: cfg_q.gear_num <= i_attr_wdata[15:0];
        epcp_pkg::ATTR_GEAR_DEN: cfg_q.gear_den <= i_attr_wdata[15:0];
        // [R6] Frequency threshold store.
        epcp_pkg::ATTR_FREQ_LIM: cfg_q.freq_lim <= i_attr_wdata[15:0];
        // [R1] Hysteresis band store.
        epcp_pkg::ATTR_HYST:     cfg_q.hyst     <= i_attr_wdata[7:0];
        // [R2] Average count store.
        epcp_pkg::ATTR_AVG:      cfg_q.avg_cnt  <= i_attr_wdata[7:0];
        // [R8] Cam enable store.
        epcp_pkg::ATTR_CAM_EN:   cfg_q.cam_en   <= i_attr_wdata[7:0];
        // [R10] Cam polarity store.
        epcp_pkg::ATTR_CAM_POL:  cfg_q.cam_pol  <= i_attr_wdata[7:0];
        default:                 ;
      endcase
    end
  end

  // [R5] Gear input uses only the raw 16-bit step field and its turn count.
  assign gear_src = {i_raw_pos[epcp_pkg::RAW_W-1:epcp_pkg::STEP_W],
                     i_raw_pos[epcp_pkg::STEP_W-1:0]};

  // The single divider serves either the gear ratio or the averaging division.
  always_comb
  begin
    div_start    = 1'b0;
    div_dividend = '0;
    div_divisor  = '0;
    if (st_q == epcp_pkg::EPCP_IDLE && i_raw_valid && gear_on)
    begin
      div_start    = 1'b1;
      // [R3] Raw position times numerator over denominator.
      div_dividend = PROD_W'(gear_src) * PROD_W'(cfg_q.gear_num);
      div_divisor  = cfg_q.gear_den;
    end
    else if (sample_vld && (cfg_q.avg_cnt > 8'h01)
             && (cnt_q + 8'h01 >= cfg_q.avg_cnt))
    begin
      div_start    = 1'b1;
      div_dividend = acc_next;
      div_divisor  = {8'h00, cfg_q.avg_cnt};
    end
  end

  // Sample entering the averager, either scaled or unscaled raw.
  always_comb
  begin
    sample     = '0;
    sample_vld = 1'b0;
    if (st_q == epcp_pkg::EPCP_GEAR && div_done)
    begin
      // [R4] Scaled result kept to 20 bits.
      sample     = {{(PROD_W-GEAR_OUT_W){1'b0}}, div_quot[epcp_pkg::GEAR_OUT_W-1:0]};
      sample_vld = 1'b1;
    end
    else if (st_q == epcp_pkg::EPCP_IDLE && i_raw_valid && !gear_on)
    begin
      sample     = {{(PROD_W-RAW_W){1'b0}}, i_raw_pos};
      sample_vld = 1'b1;
    end
  end

  assign acc_next = acc_q + sample;

  // Sequencer; raw samples that arrive while busy are dropped.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_q <= epcp_pkg::EPCP_IDLE;
    end
    else
    begin
      unique case (st_q)
        epcp_pkg::EPCP_IDLE:
          if (div_start)
            st_q <= gear_on && i_raw_valid ? epcp_pkg::EPCP_GEAR : epcp_pkg::EPCP_AVG;
        epcp_pkg::EPCP_GEAR:
          if (div_done)
            st_q <= div_start ? epcp_pkg::EPCP_AVG : epcp_pkg::EPCP_IDLE;
        epcp_pkg::EPCP_AVG:
          if (div_done)
            st_q <= epcp_pkg::EPCP_IDLE;
      endcase
    end
  end

  // [R2] Block average of the configured number of samples.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      acc_q     <= '0;
      cnt_q     <= '0;
      avg_pos_q <= '0;
      avg_vld_q <= 1'b0;
    end
    else
    begin
      avg_vld_q <= 1'b0;
      if (st_q == epcp_pkg::EPCP_AVG && div_done)
      begin
        avg_pos_q <= {{(POS_W-PROD_W){1'b0}}, div_quot};
        avg_vld_q <= 1'b1;
      end
      else if (sample_vld)
      begin
        if (cfg_q.avg_cnt <= 8'h01)
        begin
          avg_pos_q <= {{(POS_W-PROD_W){1'b0}}, sample};
          avg_vld_q <= 1'b1;
          acc_q     <= '0;
          cnt_q     <= '0;
        end
        else if (div_start)
        begin
          acc_q <= '0;
          cnt_q <= '0;
        end
        else
        begin
          acc_q <= acc_next;
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

  assign hyst_diff = signed'(avg_pos_q) - signed'(hyst_pos_q);
  assign hyst_mag  = hyst_diff[POS_W-1] ? POS_W'(-hyst_diff) : POS_W'(hyst_diff);

  // [R1] Reported value follows only moves larger than the band.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      hyst_pos_q <= '0;
      have_q     <= 1'b0;
      hyst_upd_q <= 1'b0;
    end
    else
    begin
      hyst_upd_q <= 1'b0;
      if (avg_vld_q && (!have_q || hyst_mag > {56'h0, cfg_q.hyst}))
      begin
        hyst_pos_q <= avg_pos_q;
        have_q     <= 1'b1;
        hyst_upd_q <= 1'b1;
      end
    end
  end

  // [R11] Offset is preset minus the current position.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      offset_q <= '0;
    else if (wr_preset)
      offset_q <= i_attr_wdata - hyst_pos_q;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pos_q     <= '0;
      pos_vld_q <= 1'b0;
    end
    else
    begin
      pos_q     <= hyst_pos_q + offset_q;
      pos_vld_q <= hyst_upd_q;
    end
  end

  epcp_div u_div (
    .i_clk      (i_clk),
    .i_rstn     (i_rstn),
    .i_start    (div_start),
    .i_dividend (div_dividend),
    .i_divisor  (div_divisor),
    .o_busy     (div_busy),
    .o_done     (div_done),
    .o_quot     (div_quot)
  );

  // [R15] Cam n plus one sits on bit n.
  genvar g;
  generate
    for (g = 0; g < epcp_pkg::CAM_N; g++)
    begin : g_cam
      logic in_win;
      // [R9] Within the cam's limits reads one.
      assign in_win = (signed'(pos_q) >= signed'(i_cam_lo[g]))
                   && (signed'(pos_q) <= signed'(i_cam_hi[g]));
      // [R16] Disabled cam reads zero; [R10] polarity inverts.
      assign cam_d[g] = cfg_q.cam_en[g] & (in_win ^ cfg_q.cam_pol[g]);
    end
  endgenerate

  // [R7] Cam state byte and [R14] self-clearing warnings follow the inputs.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_cam_state  <= '0;
      o_below_low  <= 1'b0;
      o_above_high <= 1'b0;
      o_warnings   <= '0;
    end
    else
    begin
      o_cam_state  <= cam_d;
      // [R12] Below lower end limit.
      o_below_low  <= signed'(pos_q) < signed'(cfg_q.end_lo);
      // [R13] Above upper end limit.
      o_above_high <= signed'(pos_q) > signed'(cfg_q.end_hi);
      o_warnings   <= '0;
      // [R6] Frequency compare.
      o_warnings[epcp_pkg::WARN_FREQ_BIT]  <= i_rot_freq > cfg_q.freq_lim;
      o_warnings[epcp_pkg::WARN_LIMIT_BIT] <= (signed'(pos_q) < signed'(cfg_q.end_lo))
                                           || (signed'(pos_q) > signed'(cfg_q.end_hi));
    end
  end

  // Attribute read port, one cycle behind the attribute number.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_attr_rdata <= '0;
      o_attr_hit   <= 1'b0;
    end
    else
    begin
      o_attr_hit <= 1'b1;
      unique case (i_attr_id)
        epcp_pkg::ATTR_PRESET:    o_attr_rdata <= cfg_q.preset;
        epcp_pkg::ATTR_OFFSET:    o_attr_rdata <= offset_q;
        epcp_pkg::ATTR_HYST:      o_attr_rdata <= {56'h0, cfg_q.hyst};
        epcp_pkg::ATTR_AVG:       o_attr_rdata <= {56'h0, cfg_q.avg_cnt};
        epcp_pkg::ATTR_GEAR_NUM:  o_attr_rdata <= {48'h0, cfg_q.gear_num};
        epcp_pkg::ATTR_GEAR_DEN:  o_attr_rdata <= {48'h0, cfg_q.gear_den};
        epcp_pkg::ATTR_END_LO:    o_attr_rdata <= cfg_q.end_lo;
        epcp_pkg::ATTR_END_HI:    o_attr_rdata <= cfg_q.end_hi;
        epcp_pkg::ATTR_FREQ_LIM:  o_attr_rdata <= {48'h0, cfg_q.freq_lim};
        epcp_pkg::ATTR_FAULT:     o_attr_rdata <= {48'h0, i_sensor_fault};
        epcp_pkg::ATTR_CAM_STATE: o_attr_rdata <= {56'h0, o_cam_state};
        epcp_pkg::ATTR_CAM_EN:    o_attr_rdata <= {56'h0, cfg_q.cam_en};
        epcp_pkg::ATTR_CAM_POL:   o_attr_rdata <= {56'h0, cfg_q.cam_pol};
        default:
        begin
          o_attr_rdata <= '0;
          o_attr_hit   <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_position  <= '0;
      o_pos_valid <= 1'b0;
      o_busy      <= 1'b0;
    end
    else
    begin
      o_position  <= pos_q;
      o_pos_valid <= pos_vld_q;
      o_busy      <= div_busy || (st_q != epcp_pkg::EPCP_IDLE);
    end
  end

endmodule : epcp_top

// [test/epcp_checker.sv]
/* Assertion checker for epcp_top, bound to its ports at the foot of this file.
   Assumes the attribute bus and sample latencies given with the design. */
`timescale 1ns/100ps
module epcp_checker (
  input wire logic                        i_clk,
  input wire logic                        i_rstn,
  input wire logic                        i_raw_valid,
  input wire logic [7:0]                  i_attr_id,
  input wire logic                        i_attr_wr,
  input wire logic [63:0]                 i_attr_wdata,
  input wire logic [63:0]                 o_attr_rdata,
  input wire logic [epcp_pkg::POS_W-1:0]  o_position,
  input wire logic                        o_pos_valid,
  input wire logic [epcp_pkg::WARN_W-1:0] o_warnings,
  input wire logic                        o_below_low,
  input wire logic                        o_above_high,
  input wire logic                        o_busy
);
  logic [1:0] live_q;
  logic       live;
  logic       cfg;

  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      live_q <= 2'h0;
    else if (live_q != 2'h3)
      live_q <= live_q + 2'h1;

  assign live = live_q == 2'h3;
  // Writable attributes are the mapped range less the three read-only ones.
  assign cfg = i_attr_id >= epcp_pkg::ATTR_PRESET && i_attr_id <= epcp_pkg::ATTR_CAM_POL &&
    !(i_attr_id inside {epcp_pkg::ATTR_OFFSET, epcp_pkg::ATTR_FAULT, epcp_pkg::ATTR_CAM_STATE});

  function automatic logic [63:0] wmask(input logic [7:0] id);
    case (id)
      epcp_pkg::ATTR_GEAR_NUM, epcp_pkg::ATTR_GEAR_DEN, epcp_pkg::ATTR_FREQ_LIM:
        wmask = 64'hffff;
      epcp_pkg::ATTR_PRESET, epcp_pkg::ATTR_END_LO, epcp_pkg::ATTR_END_HI:
        wmask = 64'hffff_ffff_ffff_ffff;
      default:
        wmask = 64'hff;
    endcase
  endfunction : wmask

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_cfg_wr;
    i_attr_wr && cfg ##1 $stable(i_attr_id) && !i_attr_wr;
  endsequence
  sequence s_off_held;
    (i_attr_id == epcp_pkg::ATTR_OFFSET) [*3];
  endsequence

  cfg_readback_a:
    assert property (s_cfg_wr |=> o_attr_rdata == ($past(i_attr_wdata, 2) &
      wmask($past(i_attr_id, 2)))) else $error("written attribute does not read back");
  ro_offset_a:
    assert property (s_off_held |-> $stable(o_attr_rdata)) else $error("offset value moved");
  warn_reserved_a:
    assert property ((o_warnings & 16'hfbfe) == 16'h0000) else $error("reserved warning set");
  limit_warn_a:
    assert property (live |-> o_warnings[epcp_pkg::WARN_LIMIT_BIT] ==
      (o_below_low || o_above_high)) else $error("limit warning disagrees with flags");
  end_excl_a:
    assert property (!(o_below_low && o_above_high)) else $error("both end flags set");
  busy_bound_a:
    assert property ($rose(o_busy) |-> ##[1:150] !o_busy) else $error("processing never ends");
  busy_cause_a:
    assert property ($rose(o_busy) |-> $past(i_raw_valid) || $past(i_raw_valid, 2) ||
      $past(i_raw_valid, 3)) else $error("processing without a sample");
  valid_moves_a:
    assert property (live && o_pos_valid |-> o_position != $past(o_position))
      else $error("valid pulse without a move");
endmodule : epcp_checker

bind epcp_top epcp_checker u_chk (.i_clk, .i_rstn, .i_raw_valid, .i_attr_id, .i_attr_wr,
  .i_attr_wdata, .o_attr_rdata, .o_position, .o_pos_valid, .o_warnings, .o_below_low,
  .o_above_high, .o_busy);

// [test/epcp_ctrl_model.sv]
/* Network controller model: writes and reads attributes of epcp_top.
   Assumes the block samples requests on rising edges; this drives on falling. */
`timescale 1ns/100ps
module epcp_ctrl_model (
  input  wire logic        i_clk,
  input  wire logic [63:0] i_attr_rdata,
  input  wire logic        i_attr_hit,
  output logic [7:0]       o_attr_id,
  output logic             o_attr_wr,
  output logic [63:0]      o_attr_wdata
);
  initial
  begin
    o_attr_id = 8'h00;
    o_attr_wr = 1'b0;
    o_attr_wdata = 64'h0;
  end

  task automatic wr(input logic [7:0] id, input logic [63:0] d);
    @(negedge i_clk);
    o_attr_id = id;
    o_attr_wr = 1'b1;
    o_attr_wdata = d;
    @(negedge i_clk);
    o_attr_wr = 1'b0;
    // Released data shows its inverse so a stale value cannot pass.
    o_attr_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] id, output logic [63:0] d, output logic hit);
    @(negedge i_clk);
    o_attr_id = id;
    repeat (2) @(negedge i_clk);
    d = i_attr_rdata;
    hit = i_attr_hit;
  endtask : rd
endmodule : epcp_ctrl_model

// [test/encoder_position_cam_processing_test.sv]
/* Self-checking test of epcp_top: attributes go through the controller model,
   raw samples, cam limits and rotation frequency are driven here.
   Assumes the reset values and latencies given with the design. */
`timescale 1ns/100ps
module encoder_position_cam_processing_test;
  logic                clk, rstn, raw_valid, attr_wr, attr_hit, pos_valid, below, above, busy;
  logic                rh;
  logic [31:0]         raw_pos;
  logic [15:0]         rot_freq, fault, warnings;
  logic [7:0]          attr_id, cam_state;
  logic [63:0]         attr_wdata, attr_rdata, position, rv;
  epcp_pkg::epcp_lim_t cam_lo, cam_hi;
  int                  mismatches, n_tests;
  logic [7:0]          ids[8] = '{8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6f, 8'h72, 8'h73, 8'h70};
  logic [63:0]         rsts[8] = '{64'h4, 64'h1, 64'h0, 64'h0, 64'hffff, 64'h0, 64'h0, 64'ha5};
  logic [31:0]         pv[3] = '{32'h300, 32'h10, 32'h105};

  epcp_top dut (.i_clk(clk), .i_rstn(rstn), .i_raw_valid(raw_valid), .i_raw_pos(raw_pos),
    .i_rot_freq(rot_freq), .i_sensor_fault(fault), .i_cam_lo(cam_lo), .i_cam_hi(cam_hi),
    .i_attr_id(attr_id), .i_attr_wr(attr_wr), .i_attr_wdata(attr_wdata),
    .o_attr_rdata(attr_rdata), .o_attr_hit(attr_hit), .o_position(position),
    .o_pos_valid(pos_valid), .o_cam_state(cam_state), .o_warnings(warnings),
    .o_below_low(below), .o_above_high(above), .o_busy(busy));

  epcp_ctrl_model ctl (.i_clk(clk), .i_attr_rdata(attr_rdata), .i_attr_hit(attr_hit),
    .o_attr_id(attr_id), .o_attr_wr(attr_wr), .o_attr_wdata(attr_wdata));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic sample(input logic [31:0] v, input logic [63:0] exp);
    int k;
    @(negedge clk);
    raw_valid = 1'b1;
    raw_pos = v;
    @(negedge clk);
    raw_valid = 1'b0;
    raw_pos = ~v;
    k = 0;
    while (pos_valid !== 1'b1 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    repeat (2) @(negedge clk);
    chk(position, exp);
  endtask : sample

  // Cam enables are 0x0f and polarities 0x03 at every check that uses this function.
  function automatic logic [7:0] cam_exp(input logic [63:0] p);
    for (int n = 0; n < 8; n++)
      cam_exp[n] = (n < 4) && (($signed(p) >= $signed(cam_lo[n]) &&
        $signed(p) <= $signed(cam_hi[n])) ^ (n < 2));
  endfunction : cam_exp

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The tests need about 650 cycles; the watchdog allows 20000.
  initial
  begin
    #1000000;
    mismatches++;
    summarize();
  end

  initial
  begin
    rstn = 1'b0;
    raw_valid = 1'b0;
    raw_pos = 32'h0;
    rot_freq = 16'h0;
    fault = 16'ha5;
    for (int n = 0; n < 8; n++)
    begin
      cam_lo[n] = n[0] ? 64'h300 : 64'h100;
      cam_hi[n] = cam_lo[n] + 64'hff;
    end
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      ctl.rd(ids[i], rv, rh);
      chk(rv, rsts[i]);
    end
    ctl.rd(8'h74, rv, rh);
    chk(rv | {63'h0, rh}, 64'h0);
    ctl.wr(epcp_pkg::ATTR_OFFSET, 64'h55);
    ctl.rd(epcp_pkg::ATTR_OFFSET, rv, rh);
    chk(rv, 64'h0);
    sample(32'h100, 64'h100);
    sample(32'h104, 64'h100);
    sample(32'h105, 64'h105);
    ctl.wr(epcp_pkg::ATTR_CAM_EN, 64'h0f);
    ctl.wr(epcp_pkg::ATTR_CAM_POL, 64'h03);
    ctl.wr(epcp_pkg::ATTR_CAM_STATE, 64'hff);
    ctl.wr(epcp_pkg::ATTR_END_LO, 64'h50);
    ctl.wr(epcp_pkg::ATTR_END_HI, 64'h200);
    ctl.rd(epcp_pkg::ATTR_CAM_STATE, rv, rh);
    chk(rv, {56'h0, cam_exp(64'h105)});
    for (int i = 0; i < 3; i++)
    begin
      sample(pv[i], {32'h0, pv[i]});
      chk({56'h0, cam_state}, {56'h0, cam_exp({32'h0, pv[i]})});
      chk({63'h0, above}, {63'h0, pv[i] > 32'h200});
      chk({63'h0, below}, {63'h0, pv[i] < 32'h50});
      chk({63'h0, warnings[10]}, {63'h0, pv[i] > 32'h200 || pv[i] < 32'h50});
    end
    ctl.wr(epcp_pkg::ATTR_FREQ_LIM, 64'h100);
    rot_freq = 16'h200;
    repeat (3) @(negedge clk);
    chk({63'h0, warnings[0]}, 64'h1);
    rot_freq = 16'h50;
    repeat (3) @(negedge clk);
    chk({63'h0, warnings[0]}, 64'h0);
    ctl.wr(epcp_pkg::ATTR_HYST, 64'hff);
    ctl.rd(epcp_pkg::ATTR_HYST, rv, rh);
    chk(rv, 64'hff);
    ctl.wr(epcp_pkg::ATTR_GEAR_NUM, 64'h3);
    ctl.wr(epcp_pkg::ATTR_GEAR_DEN, 64'h2);
    sample(32'h000c_0000, 64'h2_0000);
    ctl.wr(epcp_pkg::ATTR_GEAR_NUM, 64'h0);
    ctl.wr(epcp_pkg::ATTR_AVG, 64'h2);
    sample(32'h300, 64'h2_0000);
    sample(32'h401, 64'h380);
    ctl.wr(epcp_pkg::ATTR_PRESET, 64'h1000);
    ctl.rd(epcp_pkg::ATTR_OFFSET, rv, rh);
    chk(rv, 64'hc80);
    chk(position, 64'h1000);
    summarize();
  end
endmodule : encoder_position_cam_processing_test
